// ===== hdl/rhgs_defs.svh
// constants for the root hub global status block
`ifndef RHGS_DEFS_SVH
`define RHGS_DEFS_SVH
`define RHGS_ADDR_STATUS 4'h0
`define RHGS_ADDR_IRQ_STAT 4'h1
`define RHGS_ADDR_IRQ_MASK 4'h2
`define RHGS_ADDR_CONFIG 4'h3
`define RHGS_ADDR_PORTS 4'h4
`define RHGS_BIT_CLEAR_WAKE 31
`define RHGS_BIT_OC_CHANGE 17
`define RHGS_BIT_SET_POWER 16
`define RHGS_BIT_WAKE_EN 15
`define RHGS_BIT_OC_GLOBAL 1
`define RHGS_BIT_CLEAR_POWER 0
`define RHGS_IRQ_OC_CHANGE 0
`define RHGS_IRQ_RESUME 1
`define RHGS_IRQ_WIDTH 2
`define RHGS_CFG_SCHEME 0
`define RHGS_CFG_PERPORT_OC 1
`define RHGS_RESET_VALUE 32'h0000_0000
`endif

// ===== hdl/rhgs_pkg.sv
// types for the root hub global status block
package rhgs_pkg;
   typedef enum logic [1:0] {RHGS_OPERATIONAL, RHGS_SUSPENDED, RHGS_RESUMING} rhgs_state_e;
   typedef logic [31:0] rhgs_word_t;
endpackage

// ===== hdl/rhgs_event_flag.sv
// sticky event flag with write-one-to-clear, set wins
`timescale 1ns/1ns
`default_nettype none
module rhgs_event_flag
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // event and clear
   input wire logic set_pulse,
   input wire logic clear_pulse,
   // flag
   output logic flag
);
   logic flag_d;
   logic flag_q;

   // set beats a clear in the same cycle so no event is lost
   always_comb
   begin
      flag_d = flag_q;
      if (clear_pulse)
         flag_d = 1'b0;
      if (set_pulse)
         flag_d = 1'b1;
   end

   // register
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         flag_q <= 1'b0;
      else
         flag_q <= flag_d;
   end

   assign flag = flag_q;
endmodule
`default_nettype wire

// ===== hdl/rhgs_port_power.sv
// downstream port power state for global and per-port switching
`timescale 1ns/1ns
`default_nettype none
module rhgs_port_power
#(
   parameter int NUM_PORTS = 2
)
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // commands
   input wire logic power_on_cmd,
   input wire logic power_off_cmd,
   input wire logic power_switch_scheme,
   input wire logic [NUM_PORTS-1:0] port_power_mask,
   // state
   output logic [NUM_PORTS-1:0] port_powered_state
);
   logic [NUM_PORTS-1:0] pwr_d;
   logic [NUM_PORTS-1:0] pwr_q;
   logic [NUM_PORTS-1:0] sel;

   // elaboration check: the mask and power fields must fit the word
   if (NUM_PORTS < 1 || NUM_PORTS > 15)
   begin
      $error("rhgs_port_power: NUM_PORTS out of range");
   end

   // global mode touches every port, per-port only unmasked ones
   always_comb
   begin
      sel = power_switch_scheme ? ~port_power_mask : '1;
      pwr_d = pwr_q;
      if (power_on_cmd)
         pwr_d = pwr_q | sel;
      else if (power_off_cmd)
         pwr_d = pwr_q & ~sel;
   end

   // register
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         pwr_q <= '0;
      else
         pwr_q <= pwr_d;
   end

   assign port_powered_state = pwr_q;
endmodule
`default_nettype wire

// ===== hdl/rhgs_core.sv
// root hub global status and control register block
//
// Summary of operation
// RL1 - writing one to bit 31 clears wake enable
// RL2 - overcurrent change flag sets on indicator change
// RL3 - written one clears change flag, zero ignored
// RL4 - bit 16 always reads zero
// RL5 - global mode: bit 16 powers all ports
// RL6 - per-port mode: bit 16 powers unmasked ports
// RL7 - wake enable makes attach change resume event
// RL8 - writing one to bit 15 sets wake enable
// RL9 - bit 1 shows global overcurrent condition
// RL10 - per-port overcurrent reporting holds bit 1 zero
// RL11 - bit 0 always reads zero
// RL12 - global mode: bit 0 unpowers all ports
// RL13 - per-port mode: bit 0 unpowers unmasked ports
// RL14 - reserved bits read zero, writes ignored
//
// The plain strobed port and the register addresses were left to the implementer.
`include "rhgs_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module rhgs_core
   import rhgs_pkg::*;
#(
   parameter int NUM_PORTS = 2
)
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // root hub side
   input wire logic overcurrent_in,
   input wire logic attach_change_flag,
   input wire logic suspend_req,
   input wire logic resume_done,
   output logic [NUM_PORTS-1:0] port_powered_state,
   output logic remote_wake_enable,
   output logic suspended_state,
   output logic resuming_state,
   // interrupt
   output logic irq
);
   logic wake_d;
   logic wake_q;
   logic oc_d;
   logic oc_q;
   logic [1:0] cfg_d;
   logic [1:0] cfg_q;
   logic [NUM_PORTS-1:0] mask_d;
   logic [NUM_PORTS-1:0] mask_q;
   logic [`RHGS_IRQ_WIDTH-1:0] imask_d;
   logic [`RHGS_IRQ_WIDTH-1:0] imask_q;
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;
   rhgs_state_e state_d;
   rhgs_state_e state_q;
   logic wr_status;
   logic wr_istat;
   logic oc_change_flag;
   logic resume_seen_interrupt;
   logic resume_event;
   logic oc_changed;

   // elaboration check: power state must sit above bit 15, below bit 31
   if (NUM_PORTS < 1 || NUM_PORTS > 15)
   begin
      $error("rhgs_core: NUM_PORTS out of range");
   end

   // write decode
   function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
      return a == b;
   endfunction

   assign wr_status = reg_write && hit(reg_addr, `RHGS_ADDR_STATUS);
   assign wr_istat = reg_write && hit(reg_addr, `RHGS_ADDR_IRQ_STAT);

   // indicator forced low when overcurrent is reported per port
   assign oc_changed = (cfg_q[`RHGS_CFG_PERPORT_OC] ? 1'b0 : overcurrent_in) != oc_q; // [RL2]
   assign resume_event = wake_q && attach_change_flag && state_q == RHGS_SUSPENDED; // [RL7]

   // control registers
   always_comb
   begin
      wake_d = wake_q;
      oc_d = cfg_q[`RHGS_CFG_PERPORT_OC] ? 1'b0 : overcurrent_in; // [RL9] [RL10]
      cfg_d = cfg_q;
      mask_d = mask_q;
      imask_d = imask_q;
      if (wr_status && reg_wdata[`RHGS_BIT_WAKE_EN])
         wake_d = 1'b1; // [RL8]
      if (wr_status && reg_wdata[`RHGS_BIT_CLEAR_WAKE])
         wake_d = 1'b0; // [RL1]
      if (reg_write && hit(reg_addr, `RHGS_ADDR_CONFIG))
         cfg_d = reg_wdata[1:0];
      if (reg_write && hit(reg_addr, `RHGS_ADDR_PORTS))
         mask_d = reg_wdata[NUM_PORTS-1:0];
      if (reg_write && hit(reg_addr, `RHGS_ADDR_IRQ_MASK))
         imask_d = reg_wdata[`RHGS_IRQ_WIDTH-1:0];
   end

   // register
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wake_q <= 1'b0;
         oc_q <= 1'b0;
         cfg_q <= 2'h0;
         mask_q <= '0;
         imask_q <= '0;
      end
      else
      begin
         wake_q <= wake_d;
         oc_q <= oc_d;
         cfg_q <= cfg_d;
         mask_q <= mask_d;
         imask_q <= imask_d;
      end
   end

   // suspend state machine, only the wake path matters here
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         RHGS_OPERATIONAL:
            if (suspend_req)
               state_d = RHGS_SUSPENDED;
         RHGS_SUSPENDED:
            if (resume_event)
               state_d = RHGS_RESUMING; // [RL7]
         RHGS_RESUMING:
            if (resume_done)
               state_d = RHGS_OPERATIONAL;
         default:
            state_d = RHGS_OPERATIONAL;
      endcase
   end

   // register
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         state_q <= RHGS_OPERATIONAL;
      else
         state_q <= state_d;
   end

   // overcurrent change flag, cleared from the status word
   rhgs_event_flag u_oc_flag
   (
      .clk(clk),
      .resetn(resetn),
      .set_pulse(oc_changed), // [RL2]
      .clear_pulse(wr_status && reg_wdata[`RHGS_BIT_OC_CHANGE]), // [RL3]
      .flag(oc_change_flag)
   );

   // resume seen flag, cleared in the interrupt status word
   rhgs_event_flag u_resume_flag
   (
      .clk(clk),
      .resetn(resetn),
      .set_pulse(resume_event), // [RL7]
      .clear_pulse(wr_istat && reg_wdata[`RHGS_IRQ_RESUME]),
      .flag(resume_seen_interrupt)
   );

   // port power commands
   rhgs_port_power #(.NUM_PORTS(NUM_PORTS)) u_power
   (
      .clk(clk),
      .resetn(resetn),
      .power_on_cmd(wr_status && reg_wdata[`RHGS_BIT_SET_POWER]), // [RL5] [RL6]
      .power_off_cmd(wr_status && reg_wdata[`RHGS_BIT_CLEAR_POWER]), // [RL12] [RL13]
      .power_switch_scheme(cfg_q[`RHGS_CFG_SCHEME]),
      .port_power_mask(mask_q),
      .port_powered_state(port_powered_state)
   );

   // read mux; unmapped addresses and reserved bits read zero
   always_comb
   begin
      rdata_d = `RHGS_RESET_VALUE; // [RL4] [RL11] [RL14]
      if (reg_read && hit(reg_addr, `RHGS_ADDR_STATUS))
      begin
         rdata_d[`RHGS_BIT_OC_CHANGE] = oc_change_flag;
         rdata_d[`RHGS_BIT_WAKE_EN] = wake_q;
         rdata_d[`RHGS_BIT_OC_GLOBAL] = oc_q; // [RL9]
      end
      else if (reg_read && hit(reg_addr, `RHGS_ADDR_IRQ_STAT))
      begin
         rdata_d[`RHGS_IRQ_OC_CHANGE] = oc_change_flag;
         rdata_d[`RHGS_IRQ_RESUME] = resume_seen_interrupt;
      end
      else if (reg_read && hit(reg_addr, `RHGS_ADDR_IRQ_MASK))
         rdata_d[`RHGS_IRQ_WIDTH-1:0] = imask_q;
      else if (reg_read && hit(reg_addr, `RHGS_ADDR_CONFIG))
         rdata_d[1:0] = cfg_q;
      else if (reg_read && hit(reg_addr, `RHGS_ADDR_PORTS))
      begin
         rdata_d[NUM_PORTS-1:0] = mask_q;
         rdata_d[NUM_PORTS+15:16] = port_powered_state;
      end
   end

   // read data stand one cycle only
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         rdata_q <= `RHGS_RESET_VALUE;
      else
         rdata_q <= rdata_d;
   end

   assign reg_rdata = rdata_q;
   assign remote_wake_enable = wake_q;
   assign suspended_state = state_q == RHGS_SUSPENDED;
   assign resuming_state = state_q == RHGS_RESUMING;
   assign irq = |({resume_seen_interrupt, oc_change_flag} & imask_q);

   // checks
   property p_clear_wake;
      @(posedge clk) disable iff (!resetn)
      wr_status && reg_wdata[`RHGS_BIT_CLEAR_WAKE] |=> !remote_wake_enable;
   endproperty
   a_clear_wake: assert property (p_clear_wake) else $error("wake enable not cleared"); // [RL1]

   property p_set_wake;
      @(posedge clk) disable iff (!resetn)
      wr_status && reg_wdata[`RHGS_BIT_WAKE_EN] && !reg_wdata[`RHGS_BIT_CLEAR_WAKE]
      |=> remote_wake_enable;
   endproperty
   a_set_wake: assert property (p_set_wake) else $error("wake enable not set"); // [RL8]

   property p_oc_change;
      @(posedge clk) disable iff (!resetn)
      ##1 $changed(oc_q) |-> oc_change_flag;
   endproperty
   a_oc_change: assert property (p_oc_change) else $error("overcurrent change missed"); // [RL2]

   property p_oc_clear;
      @(posedge clk) disable iff (!resetn)
      wr_status && reg_wdata[`RHGS_BIT_OC_CHANGE] && !oc_changed |=> !oc_change_flag;
   endproperty
   a_oc_clear: assert property (p_oc_clear) else $error("change flag not cleared"); // [RL3]

   property p_status_zero;
      @(posedge clk) disable iff (!resetn)
      reg_read && hit(reg_addr, `RHGS_ADDR_STATUS)
      |=> reg_rdata[16] == 1'b0 && reg_rdata[0] == 1'b0 && reg_rdata[30:18] == 13'h0
          && reg_rdata[14:2] == 13'h0;
   endproperty
   a_status_zero: assert property (p_status_zero) // [RL4] [RL11] [RL14]
      else $error("fixed bits nonzero");

   property p_perport_oc;
      @(posedge clk) disable iff (!resetn)
      cfg_q[`RHGS_CFG_PERPORT_OC] |=> !oc_q;
   endproperty
   a_perport_oc: assert property (p_perport_oc) else $error("global indicator not zero"); // [RL10]

   property p_oc_follow;
      @(posedge clk) disable iff (!resetn)
      !cfg_q[`RHGS_CFG_PERPORT_OC] |=> oc_q == $past(overcurrent_in);
   endproperty
   a_oc_follow: assert property (p_oc_follow) else $error("indicator wrong"); // [RL9]

   property p_global_on;
      @(posedge clk) disable iff (!resetn)
      wr_status && reg_wdata[`RHGS_BIT_SET_POWER] && !cfg_q[`RHGS_CFG_SCHEME]
      |=> &port_powered_state;
   endproperty
   a_global_on: assert property (p_global_on) else $error("ports not powered"); // [RL5]

   property p_global_off;
      @(posedge clk) disable iff (!resetn)
      wr_status && !reg_wdata[`RHGS_BIT_SET_POWER] && reg_wdata[`RHGS_BIT_CLEAR_POWER]
      && !cfg_q[`RHGS_CFG_SCHEME] |=> port_powered_state == '0;
   endproperty
   a_global_off: assert property (p_global_off) else $error("ports not unpowered"); // [RL12]

   property p_masked_keep;
      @(posedge clk) disable iff (!resetn)
      wr_status && cfg_q[`RHGS_CFG_SCHEME]
      |=> (port_powered_state & $past(mask_q)) == ($past(port_powered_state) & $past(mask_q));
   endproperty
   a_masked_keep: assert property (p_masked_keep) // [RL6] [RL13]
      else $error("masked port changed");

   property p_resume;
      @(posedge clk) disable iff (!resetn)
      resume_event |=> resuming_state && resume_seen_interrupt;
   endproperty
   a_resume: assert property (p_resume) else $error("resume not taken"); // [RL7]

   c_resume: cover property (@(posedge clk) disable iff (!resetn) resume_event);
   c_oc: cover property (@(posedge clk) disable iff (!resetn) oc_changed && irq);
   c_perport: cover property (@(posedge clk) disable iff (!resetn)
      wr_status && cfg_q[`RHGS_CFG_SCHEME] && reg_wdata[`RHGS_BIT_SET_POWER]);
endmodule
`default_nettype wire

// ===== testbench/rhgs_testbench.sv
// self-checking bench for the root hub global status block
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import rhgs_pkg::*;
   localparam int NP = 2;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [31:0] reg_rdata;
   logic overcurrent_in = 1'b0;
   logic attach_change_flag = 1'b0;
   logic suspend_req = 1'b0;
   logic resume_done = 1'b0;
   logic [NP-1:0] port_powered_state;
   logic remote_wake_enable;
   logic suspended_state;
   logic resuming_state;
   logic irq;
   int n_errors = 0;
   int checks_done = 0;
   logic [31:0] seed = 32'h0000_0032;
   logic [NP-1:0] mask;
   logic [NP-1:0] pw;

   rhgs_core #(.NUM_PORTS(NP)) DUT (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .overcurrent_in(overcurrent_in),
      .attach_change_flag(attach_change_flag), .suspend_req(suspend_req),
      .resume_done(resume_done), .port_powered_state(port_powered_state),
      .remote_wake_enable(remote_wake_enable), .suspended_state(suspended_state),
      .resuming_state(resuming_state), .irq(irq));

   // 10 MHz clock
   always #50 clk = ~clk;

   // xorshift source, fixed start so runs repeat
   function automatic logic [31:0] next_rand();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // expected port power after an on/off command under a given scheme
   function automatic logic [NP-1:0] power_exp(input logic per_port, input logic [NP-1:0] m,
      input logic on, input logic [NP-1:0] prev);
      logic [NP-1:0] sel;
      sel = per_port ? ~m : {NP{1'b1}};
      return on ? (prev | sel) : (prev & ~sel);
   endfunction

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
         n_errors++;
      end
   endtask

   // one-cycle write strobe, effects settled on return
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
      #1;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string nm);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      chk(nm, exp, reg_rdata);
   endtask

   // one-cycle pulse on a root hub side input
   task automatic evt(input int k);
      @(posedge clk);
      if (k == 0) suspend_req <= 1'b1;
      else if (k == 1) attach_change_flag <= 1'b1;
      else resume_done <= 1'b1;
      @(posedge clk);
      suspend_req <= 1'b0;
      attach_change_flag <= 1'b0;
      resume_done <= 1'b0;
      #1;
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // watchdog, the whole sequence needs well under 2000 cycles
   initial
   begin
      #(100 * 20000);
      n_errors++;
      print_verdict();
   end

   initial
   begin
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      // reset values and an unmapped index
      rd(4'h0, 32'h0000_0000, "status reset");
      rd(4'h2, 32'h0000_0000, "mask reset");
      rd(4'h9, 32'h0000_0000, "unmapped read");
      $display("test reset done");
      // wake enable set, zero ignored, clear, clear beats set
      wr(4'h0, 32'h0000_8000);
      chk("wake set", 32'h1, {31'h0, remote_wake_enable});
      rd(4'h0, 32'h0000_8000, "status wake");
      wr(4'h0, 32'h0000_0000);
      chk("wake zero write", 32'h1, {31'h0, remote_wake_enable});
      wr(4'h0, 32'h8000_0000);
      chk("wake clear", 32'h0, {31'h0, remote_wake_enable});
      wr(4'h0, 32'h0000_8000);
      wr(4'h0, 32'h8000_8000);
      chk("wake clear wins", 32'h0, {31'h0, remote_wake_enable});
      $display("test wake done");
      // overcurrent indicator and change flag
      overcurrent_in <= 1'b1;
      repeat (3) @(posedge clk);
      rd(4'h0, 32'h0002_0002, "oc rise");
      wr(4'h0, 32'h0000_0000);
      rd(4'h0, 32'h0002_0002, "oc change zero write");
      wr(4'h2, 32'h0000_0001);
      chk("irq oc", 32'h1, {31'h0, irq});
      wr(4'h0, 32'h0002_0000);
      rd(4'h0, 32'h0000_0002, "oc change clear");
      overcurrent_in <= 1'b0;
      repeat (3) @(posedge clk);
      rd(4'h0, 32'h0002_0000, "oc fall");
      wr(4'h0, 32'h0002_0000);
      wr(4'h1, 32'h0000_0003);
      wr(4'h2, 32'h0000_0000);
      chk("irq masked off", 32'h0, {31'h0, irq});
      // per-port overcurrent reporting holds the indicator low
      wr(4'h3, 32'h0000_0002);
      overcurrent_in <= 1'b1;
      repeat (3) @(posedge clk);
      wr(4'h0, 32'h0002_0000);
      rd(4'h0, 32'h0000_0000, "oc per-port");
      overcurrent_in <= 1'b0;
      wr(4'h3, 32'h0000_0000);
      repeat (3) @(posedge clk);
      wr(4'h0, 32'h0002_0000);
      $display("test overcurrent done");
      // power switching, both schemes, random masks
      pw = '0;
      for (int i = 0; i < 12; i++)
      begin
         logic pp;
         logic on;
         pp = next_rand() & 32'h1;
         on = next_rand() & 32'h1;
         mask = next_rand();
         wr(4'h3, {31'h0, pp});
         wr(4'h4, {{(32-NP){1'b0}}, mask});
         wr(4'h0, on ? 32'h0001_0000 : 32'h0000_0001);
         pw = power_exp(pp, mask, on, pw);
         chk("port power", 32'(pw), 32'(port_powered_state));
         rd(4'h0, 32'h0000_0000, "power bits read");
      end
      // per-port corner: port 0 masked, the rest switch
      mask = '0;
      mask[0] = 1'b1;
      wr(4'h3, 32'h0000_0001);
      wr(4'h4, 32'(mask));
      wr(4'h0, 32'h0001_0000);
      pw = power_exp(1'b1, mask, 1'b1, pw);
      chk("per-port on", 32'(pw), 32'(port_powered_state));
      wr(4'h0, 32'h0000_0001);
      pw = power_exp(1'b1, mask, 1'b0, pw);
      chk("per-port off", 32'(pw), 32'(port_powered_state));
      wr(4'h3, 32'h0000_0000);
      wr(4'h0, 32'h0001_0000);
      chk("global on", 32'({NP{1'b1}}), 32'(port_powered_state));
      wr(4'h0, 32'h0000_0001);
      chk("global off", 32'h0, {{(32-NP){1'b0}}, port_powered_state});
      $display("test power done");
      // reserved bits ignore random writes
      for (int i = 0; i < 6; i++)
      begin
         wr(4'h0, next_rand() & 32'h7ffc_7ffe);
         rd(4'h0, 32'h0000_0000, "reserved");
      end
      $display("test reserved done");
      // attach change wakes only with wake enable set
      evt(0);
      chk("suspended", 32'h1, {31'h0, suspended_state});
      evt(1);
      chk("no wake", 32'h0, {31'h0, resuming_state});
      wr(4'h1, 32'h0000_0003);
      wr(4'h0, 32'h0000_8000);
      wr(4'h2, 32'h0000_0002);
      evt(1);
      repeat (2) @(posedge clk);
      chk("resume", 32'h1, {31'h0, resuming_state});
      chk("resume irq", 32'h1, {31'h0, irq});
      rd(4'h1, 32'h0000_0002, "resume status");
      wr(4'h1, 32'h0000_0002);
      chk("resume irq clear", 32'h0, {31'h0, irq});
      evt(2);
      repeat (2) @(posedge clk);
      chk("operational", 32'h0, {30'h0, suspended_state, resuming_state});
      $display("test resume done");
      print_verdict();
   end
endmodule
`default_nettype wire
